// File: inc/uig_map.vh
`ifndef UIG_MAP_VH
`define UIG_MAP_VH
// Byte addresses of the register window.
`define UIG_ADDR_DIV_LOW 32'hE000C000
`define UIG_ADDR_MASK 32'hE000C004
`define UIG_ADDR_LCTRL 32'hE000C00C
`define UIG_ADDR_LSTAT 32'hE000C014
`define UIG_ADDR_EVSTAT 32'hE000C040
`define UIG_ADDR_EVMASK 32'hE000C044
// Interrupt source mask field positions.
`define UIG_MASK_RXAV 0
`define UIG_MASK_TXE 1
`define UIG_MASK_RLS 2
`define UIG_MASK_ABEO 8
`define UIG_MASK_ABTO 9
// Writable bits of the source mask; the rest read as zero.
`define UIG_MASK_IMPL 32'h00000307
`define UIG_MASK_RST 32'h00000000
// Divisor latch reset values.
`define UIG_DIV_LOW_RST 8'h01
`define UIG_DIV_HIGH_RST 8'h00
// Line control: divisor access select bit.
`define UIG_LCTRL_DAS 7
// Line status field positions.
`define UIG_LSTAT_RDR 0
`define UIG_LSTAT_ERR_LO 1
`define UIG_LSTAT_TXE 5
// Event layout: one bit per source, shared by event status and event mask.
`define UIG_EV_RXAV 0
`define UIG_EV_CTI 1
`define UIG_EV_TXE 2
`define UIG_EV_RLS 3
`define UIG_EV_ABEO 4
`define UIG_EV_ABTO 5
`define UIG_EV_W 6
`define UIG_EV_RST 6'h00
// AXI responses.
`define UIG_RESP_OKAY 2'h0
`define UIG_RESP_SLVERR 2'h2
`endif

// File: rtl/uig_gate.v
`timescale 1ns/1ps
`default_nettype none
`include "uig_map.vh"
module uig_gate (
  input wire [31:0] mask,
  input wire rx_avail,
  input wire rx_tmo,
  input wire tx_empty,
  input wire line_err,
  input wire ab_done,
  input wire ab_tmo,
  output wire [`UIG_EV_W-1:0] gated
);
  // Each source passes only while its enable bit is one.
  assign gated[`UIG_EV_RXAV] = rx_avail & mask[`UIG_MASK_RXAV];
  // The time-out source has no enable of its own and shares the data-available bit.
  assign gated[`UIG_EV_CTI] = rx_tmo & mask[`UIG_MASK_RXAV];
  assign gated[`UIG_EV_TXE] = tx_empty & mask[`UIG_MASK_TXE];
  assign gated[`UIG_EV_RLS] = line_err & mask[`UIG_MASK_RLS];
  assign gated[`UIG_EV_ABEO] = ab_done & mask[`UIG_MASK_ABEO];
  assign gated[`UIG_EV_ABTO] = ab_tmo & mask[`UIG_MASK_ABTO];
endmodule
`default_nettype wire

// File: rtl/uig_sticky.v
`timescale 1ns/1ps
`default_nettype none
module uig_sticky #(
  parameter W = 6
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] lvl,
  input wire [W-1:0] clr,
  output reg [W-1:0] flag_q
);
  reg [W-1:0] prev_q;
  wire [W-1:0] rise;
  wire [W-1:0] flag_d;

  // A rising level sets its flag; the set beats a clear in the same cycle.
  assign rise = lvl & ~prev_q;
  assign flag_d = (flag_q & ~clr) | rise;

  // Both registers clear to zero under the synchronous reset.
  always @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= {W{1'b0}};
      flag_q <= {W{1'b0}};
    end else begin
      prev_q <= lvl;
      flag_q <= flag_d;
    end
  end
endmodule
`default_nettype wire

// File: rtl/uig_top.v
// Operation
// - Mask bit 0 gates the receive-data-available source onto the request.
// - Mask bit 0 also gates the character time-out source.
// - Mask bit 1 gates transmit-holding-empty; line status bit 5 stays readable.
// - Mask bit 2 gates line errors; line status bits 4:1 stay readable.
// - Mask bit 8 gates the auto-baud completed source.
// - Mask bit 9 gates the auto-baud time-out source.
// - The mask register answers at its address only while divisor select is zero.
// - The divisor is sixteen bits: high byte above, low byte below.
// - With divisor select one, the mask address reaches the divisor high byte.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uig_map.vh"
module uig_top (
  input wire MCLK,
  input wire RST_N,
  input wire [31:0] S_AXI_AWADDR,
  input wire [2:0] S_AXI_AWPROT,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire [2:0] S_AXI_ARPROT,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire RX_DATA_AVAIL,
  input wire RX_TIMEOUT,
  input wire TX_HOLDING_EMPTY,
  input wire [3:0] LINE_ERR,
  input wire AUTOBAUD_DONE,
  input wire AUTOBAUD_TIMEOUT,
  output reg [15:0] DIVISOR,
  output reg DIVISOR_ACCESS_SEL,
  output reg [`UIG_EV_W-1:0] GATED_PENDING,
  output reg UART_IRQ,
  output reg EVENT_IRQ
);
  // Write channel holding registers.
  reg aw_full_q;
  reg [31:0] aw_addr_q;
  reg w_full_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  // Programmable state.
  reg [31:0] interrupt_source_mask_q;
  reg [7:0] div_low_q;
  reg [7:0] divisor_high_byte_q;
  reg [7:0] lctrl_q;
  reg [`UIG_EV_W-1:0] ev_mask_q;
  // Registered view of the line status inputs.
  reg [7:0] line_status_reg_q;
  // Decode and next-value signals.
  wire [31:0] wa;
  wire [31:0] ra;
  wire do_write;
  wire do_read;
  wire divisor_access_sel;
  wire line_err_any;
  wire [`UIG_EV_W-1:0] gated;
  wire [`UIG_EV_W-1:0] ev_status;
  wire [31:0] mask_impl;
  reg [`UIG_EV_W-1:0] ev_clr;
  reg wr_hit;
  reg [31:0] interrupt_source_mask_d;
  reg [7:0] div_low_d;
  reg [7:0] divisor_high_byte_d;
  reg [7:0] lctrl_d;
  reg [`UIG_EV_W-1:0] ev_mask_d;
  reg rd_hit;
  reg [31:0] rd_data;

  // Protection bits carry no meaning for this block.
  assign wa = {aw_addr_q[31:2], 2'b00};
  assign ra = {S_AXI_ARADDR[31:2], 2'b00};
  assign divisor_access_sel = lctrl_q[`UIG_LCTRL_DAS];
  assign line_err_any = |LINE_ERR;
  assign mask_impl = `UIG_MASK_IMPL;
  // A write is carried out once address and data are both held and no response waits.
  assign do_write = aw_full_q & w_full_q & ~S_AXI_BVALID;
  assign do_read = S_AXI_ARVALID & S_AXI_ARREADY;

  // Enable gating of the six interrupt sources.
  uig_gate u_gate (
    .mask(interrupt_source_mask_q),
    .rx_avail(RX_DATA_AVAIL),
    .rx_tmo(RX_TIMEOUT),
    .tx_empty(TX_HOLDING_EMPTY),
    .line_err(line_err_any),
    .ab_done(AUTOBAUD_DONE),
    .ab_tmo(AUTOBAUD_TIMEOUT),
    .gated(gated)
  );

  // Sticky event flags, set by the rise of each enabled source.
  uig_sticky #(
    .W(`UIG_EV_W)
  ) u_sticky (
    .clk(MCLK),
    .rst_n(RST_N),
    .lvl(gated),
    .clr(ev_clr),
    .flag_q(ev_status)
  );

  // Write address channel: take one address and hold it until the write is done.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end else begin
        S_AXI_AWREADY <= ~aw_full_q & ~S_AXI_BVALID;
      end
    end
  end

  // Write data channel: same scheme, so address and data may come in either order.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end else begin
        S_AXI_WREADY <= ~w_full_q & ~S_AXI_BVALID;
      end
    end
  end

  // Write decode; the byte lanes outside each field are ignored.
  always @* begin
    wr_hit = 1'b0;
    ev_clr = {`UIG_EV_W{1'b0}};
    interrupt_source_mask_d = interrupt_source_mask_q;
    div_low_d = div_low_q;
    divisor_high_byte_d = divisor_high_byte_q;
    lctrl_d = lctrl_q;
    ev_mask_d = ev_mask_q;
    if (do_write) begin
      case (wa)
        `UIG_ADDR_DIV_LOW: begin
          // The low divisor byte shares its address with the receive buffer.
          wr_hit = divisor_access_sel;
          if (divisor_access_sel && w_strb_q[0]) begin
            div_low_d = w_data_q[7:0];
          end
        end
        `UIG_ADDR_MASK: begin
          wr_hit = 1'b1;
          if (divisor_access_sel) begin
            if (w_strb_q[0]) begin
              divisor_high_byte_d = w_data_q[7:0];
            end
          end else begin
            // Unused bits are not stored, so any value software leaves there is harmless.
            if (w_strb_q[0]) begin
              interrupt_source_mask_d[7:0] = w_data_q[7:0] & mask_impl[7:0];
            end
            if (w_strb_q[1]) begin
              interrupt_source_mask_d[15:8] = w_data_q[15:8] & mask_impl[15:8];
            end
          end
        end
        `UIG_ADDR_LCTRL: begin
          wr_hit = 1'b1;
          if (w_strb_q[0]) begin
            lctrl_d = w_data_q[7:0];
          end
        end
        `UIG_ADDR_LSTAT: begin
          // Line status is read only; a write is accepted and dropped.
          wr_hit = 1'b1;
        end
        `UIG_ADDR_EVSTAT: begin
          wr_hit = 1'b1;
          if (w_strb_q[0]) begin
            ev_clr = w_data_q[`UIG_EV_W-1:0];
          end
        end
        `UIG_ADDR_EVMASK: begin
          wr_hit = 1'b1;
          if (w_strb_q[0]) begin
            ev_mask_d = w_data_q[`UIG_EV_W-1:0];
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end
  end

  // Programmable registers; every enable starts cleared.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      interrupt_source_mask_q <= `UIG_MASK_RST;
      div_low_q <= `UIG_DIV_LOW_RST;
      divisor_high_byte_q <= `UIG_DIV_HIGH_RST;
      lctrl_q <= 8'h00;
      ev_mask_q <= `UIG_EV_RST;
    end else begin
      interrupt_source_mask_q <= interrupt_source_mask_d;
      div_low_q <= div_low_d;
      divisor_high_byte_q <= divisor_high_byte_d;
      lctrl_q <= lctrl_d;
      ev_mask_q <= ev_mask_d;
    end
  end

  // Write response, one cycle after the write is carried out.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `UIG_RESP_OKAY;
    end else begin
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? `UIG_RESP_OKAY : `UIG_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read decode; reserved bits read as zero.
  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    case (ra)
      `UIG_ADDR_DIV_LOW: begin
        // With divisor select clear this address belongs to the receive buffer,
        // which lives outside this block, so it reads zero here.
        if (divisor_access_sel) begin
          rd_data[7:0] = div_low_q;
        end
      end
      `UIG_ADDR_MASK: begin
        if (divisor_access_sel) begin
          rd_data[7:0] = divisor_high_byte_q;
        end else begin
          rd_data = interrupt_source_mask_q;
        end
      end
      `UIG_ADDR_LCTRL: begin
        rd_data[7:0] = lctrl_q;
      end
      `UIG_ADDR_LSTAT: begin
        // Raw conditions, whatever the enables say.
        rd_data[7:0] = line_status_reg_q;
      end
      `UIG_ADDR_EVSTAT: begin
        rd_data[`UIG_EV_W-1:0] = ev_status;
      end
      `UIG_ADDR_EVMASK: begin
        rd_data[`UIG_EV_W-1:0] = ev_mask_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one read at a time, data one cycle after the address is taken.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `UIG_RESP_OKAY;
    end else begin
      if (do_read) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_data;
        S_AXI_RRESP <= rd_hit ? `UIG_RESP_OKAY : `UIG_RESP_SLVERR;
      end else if (S_AXI_RVALID) begin
        if (S_AXI_RREADY) begin
          S_AXI_RVALID <= 1'b0;
        end
      end else begin
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Line status snapshot; the enables never touch these bits.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      line_status_reg_q <= 8'h00;
    end else begin
      line_status_reg_q <= 8'h00;
      line_status_reg_q[`UIG_LSTAT_RDR] <= RX_DATA_AVAIL;
      line_status_reg_q[`UIG_LSTAT_ERR_LO+3:`UIG_LSTAT_ERR_LO] <= LINE_ERR;
      line_status_reg_q[`UIG_LSTAT_TXE] <= TX_HOLDING_EMPTY;
    end
  end

  // Outputs to the baud generator and the interrupt controller.
  // The request follows the gated level with one cycle of delay; the
  // identification logic outside decides priority among the pending sources.
  always @(posedge MCLK) begin
    if (!RST_N) begin
      DIVISOR <= {`UIG_DIV_HIGH_RST, `UIG_DIV_LOW_RST};
      DIVISOR_ACCESS_SEL <= 1'b0;
      GATED_PENDING <= {`UIG_EV_W{1'b0}};
      UART_IRQ <= 1'b0;
      EVENT_IRQ <= 1'b0;
    end else begin
      DIVISOR <= {divisor_high_byte_q, div_low_q};
      DIVISOR_ACCESS_SEL <= divisor_access_sel;
      GATED_PENDING <= gated;
      UART_IRQ <= |gated;
      EVENT_IRQ <= |(ev_status & ev_mask_q);
    end
  end
endmodule
`default_nettype wire

// File: verification/uig_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "uig_map.vh"
module uig_checker (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic RX_DATA_AVAIL,
  input wire logic RX_TIMEOUT,
  input wire logic TX_HOLDING_EMPTY,
  input wire logic [3:0] LINE_ERR,
  input wire logic AUTOBAUD_DONE,
  input wire logic AUTOBAUD_TIMEOUT,
  input wire logic S_AXI_BVALID,
  input wire logic [15:0] DIVISOR,
  input wire logic DIVISOR_ACCESS_SEL,
  input wire logic [`UIG_EV_W-1:0] GATED_PENDING,
  input wire logic UART_IRQ
);
  // The first four gated bits may only stand, and the two auto-baud bits only rise, when the raw source stood one cycle earlier.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_rxav; GATED_PENDING[`UIG_EV_RXAV] |-> $past(RX_DATA_AVAIL); endproperty
  a_rxav: assert property (p_rxav) else $error("data pending without source");
  property p_cti; GATED_PENDING[`UIG_EV_CTI] |-> $past(RX_TIMEOUT); endproperty
  a_cti: assert property (p_cti) else $error("cti pending without source");
  property p_txe; GATED_PENDING[`UIG_EV_TXE] |-> $past(TX_HOLDING_EMPTY); endproperty
  a_txe: assert property (p_txe) else $error("empty pending without source");
  property p_rls; GATED_PENDING[`UIG_EV_RLS] |-> $past(|LINE_ERR); endproperty
  a_rls: assert property (p_rls) else $error("error pending without source");
  property p_abd; $rose(GATED_PENDING[`UIG_EV_ABEO]) |-> $past(AUTOBAUD_DONE); endproperty
  a_abd: assert property (p_abd) else $error("done pending without source");
  property p_abt; $rose(GATED_PENDING[`UIG_EV_ABTO]) |-> $past(AUTOBAUD_TIMEOUT); endproperty
  a_abt: assert property (p_abt) else $error("timeout pending without source");
  // The request is the plain OR of the gated sources, with no extra delay.
  property p_irq; UART_IRQ == (|GATED_PENDING); endproperty
  a_irq: assert property (p_irq) else $error("request differs from gated sources");
  // Enables start cleared, so nothing may pass for two cycles after reset ends.
  property p_rst; $rose(RST_N) |-> GATED_PENDING == '0 ##1 GATED_PENDING == '0; endproperty
  a_rst: assert property (p_rst) else $error("source gated right after reset");
  // The divisor may only move after a write made while divisor select is one.
  property p_div; $changed(DIVISOR) |-> $past(S_AXI_BVALID) && DIVISOR_ACCESS_SEL; endproperty
  a_div: assert property (p_div) else $error("divisor moved without selected write");
endmodule
bind uig_top uig_checker u_chk (.MCLK(MCLK), .RST_N(RST_N), .RX_DATA_AVAIL(RX_DATA_AVAIL),
  .RX_TIMEOUT(RX_TIMEOUT), .TX_HOLDING_EMPTY(TX_HOLDING_EMPTY), .LINE_ERR(LINE_ERR),
  .AUTOBAUD_DONE(AUTOBAUD_DONE), .AUTOBAUD_TIMEOUT(AUTOBAUD_TIMEOUT),
  .S_AXI_BVALID(S_AXI_BVALID), .DIVISOR(DIVISOR), .DIVISOR_ACCESS_SEL(DIVISOR_ACCESS_SEL),
  .GATED_PENDING(GATED_PENDING), .UART_IRQ(UART_IRQ));
`default_nettype wire

// File: verification/uig_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module uig_far_model (
  input wire logic clk,
  input wire logic [5:0] ev,
  input wire logic [3:0] err,
  output wire logic rx_avail,
  output wire logic rx_tmo,
  output wire logic tx_empty,
  output wire logic [3:0] line_err,
  output wire logic ab_done,
  output wire logic ab_tmo
);
  // Line conditions change only just after an edge, as the real receiver would.
  logic [9:0] q = 10'h000;
  always @(posedge clk) begin
    q <= {err, ev};
  end
  // Error bits only show while the error condition is requested.
  assign rx_avail = q[0];
  assign rx_tmo = q[1];
  assign tx_empty = q[2];
  assign ab_done = q[4];
  assign ab_tmo = q[5];
  assign line_err = q[3] ? q[9:6] : 4'h0;
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uig_map.vh"
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rd_data;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [1:0] rsp;
  logic [5:0] src;
  logic [3:0] err;
  wire awready, wready, bvalid, arready, rvalid, rx_avail, rx_tmo, tx_empty, ab_done, ab_tmo;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] line_err;
  wire [15:0] divisor;
  wire div_sel, uart_irq, event_irq;
  wire [`UIG_EV_W-1:0] gated;
  int err_total = 0;
  int n_compared = 0;
  // Rows hold mask, raw sources and the gated pattern they should give.
  logic [27:0] rows [0:8] = '{
    28'h000_3F_00,
    28'h001_3F_03,
    28'h001_02_02,
    28'h002_3F_04,
    28'h004_3F_08,
    28'h100_3F_10,
    28'h200_3F_20,
    28'h307_00_00,
    28'h307_3F_3F};
  uig_far_model u_far (.clk(mclk), .ev(src), .err(err), .rx_avail(rx_avail), .rx_tmo(rx_tmo),
    .tx_empty(tx_empty), .line_err(line_err), .ab_done(ab_done), .ab_tmo(ab_tmo));
  uig_top u_dut (.MCLK(mclk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .RX_DATA_AVAIL(rx_avail), .RX_TIMEOUT(rx_tmo), .TX_HOLDING_EMPTY(tx_empty),
    .LINE_ERR(line_err), .AUTOBAUD_DONE(ab_done), .AUTOBAUD_TIMEOUT(ab_tmo),
    .DIVISOR(divisor), .DIVISOR_ACCESS_SEL(div_sel), .GATED_PENDING(gated),
    .UART_IRQ(uart_irq), .EVENT_IRQ(event_irq));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    rsp = rresp;
    rd_data = rdata;
  endtask
  // Sampling one step after the edge lets that edge's updates land first.
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    src = 6'h00;
    err = 4'hF;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(`UIG_ADDR_MASK, {20'h00000, rows[i][27:16]});
      src <= rows[i][13:8];
      hold(3);
      chk(gated, rows[i][5:0]);
      chk(uart_irq, |rows[i][5:0]);
    end
    $display("test gating done");
    // A reset in mid-run, with every source still raised.
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    hold(1);
    chk(gated, 6'h00);
    chk(uart_irq, 1'b0);
    chk(divisor, 16'h0001);
    rd(`UIG_ADDR_MASK);
    chk(rd_data & `UIG_MASK_IMPL, 32'h00000000);
    src <= 6'h0C;
    err <= 4'h5;
    hold(3);
    rd(`UIG_ADDR_LSTAT);
    chk(rd_data & 32'h0000003F, 32'h0000002A);
    chk(gated, 6'h00);
    $display("test reset done");
    wr(`UIG_ADDR_MASK, 32'h00000307);
    chk(rsp, `UIG_RESP_OKAY);
    rd(`UIG_ADDR_MASK);
    chk(rd_data & `UIG_MASK_IMPL, 32'h00000307);
    wr(`UIG_ADDR_LCTRL, 32'h00000080);
    // The select output follows the register one edge later.
    hold(1);
    chk(div_sel, 1'b1);
    wr(`UIG_ADDR_MASK, 32'h000000A5);
    wr(`UIG_ADDR_DIV_LOW, 32'h0000003C);
    hold(2);
    chk(divisor, 16'hA53C);
    rd(`UIG_ADDR_MASK);
    chk(rd_data[7:0], 8'hA5);
    wr(`UIG_ADDR_LCTRL, 32'h00000000);
    rd(`UIG_ADDR_MASK);
    chk(rd_data & `UIG_MASK_IMPL, 32'h00000307);
    $display("test divisor done");
    src <= 6'h00;
    hold(3);
    wr(`UIG_ADDR_EVSTAT, 32'h0000003F);
    wr(`UIG_ADDR_EVMASK, 32'h00000001);
    src <= 6'h01;
    hold(4);
    chk(event_irq, 1'b1);
    rd(`UIG_ADDR_EVSTAT);
    chk(rd_data & 32'h0000003F, 32'h00000001);
    wr(`UIG_ADDR_EVMASK, 32'h00000000);
    hold(2);
    chk(event_irq, 1'b0);
    @(posedge mclk);
    src <= 6'h00;
    wr(`UIG_ADDR_EVSTAT, 32'h00000001);
    wr(`UIG_ADDR_EVMASK, 32'h00000001);
    hold(2);
    chk(event_irq, 1'b0);
    rd(32'hE000C100);
    chk(rsp, `UIG_RESP_SLVERR);
    chk(rd_data, 32'h00000000);
    wr(32'hE000C100, 32'h00000000);
    chk(rsp, `UIG_RESP_SLVERR);
    $display("test events done");
    give_verdict();
  end
endmodule
`default_nettype wire
